// ### occ_pkg.sv
// Package: register map, field layout, reset values and timing counts
// for the oscillator control and calibration block.
// Assumes an 8-bit register port with a 5-bit byte address.
package occ_pkg;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [4:0] OFS_STATUS     = 5'h03;
    localparam logic [4:0] OFS_FAST_CTRL  = 5'h10;
    localparam logic [4:0] OFS_FAST_TRIM  = 5'h11;
    localparam logic [4:0] OFS_FAST_TEMP  = 5'h12;
    localparam logic [4:0] OFS_SLOW_CTRL  = 5'h18;
    localparam logic [4:0] OFS_XTAL_CTRL  = 5'h1C;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int BIT_KEEP_RUN   = 1;
    localparam int BIT_XTAL_EN    = 0;
    localparam int BIT_XTAL_SEL   = 2;
    localparam int POS_CRYSTAL_STARTUP_SEL       = 4;
    localparam int BIT_CAL_LOCK   = 7;
    localparam int BIT_ST_XTAL    = 6;
    localparam int BIT_ST_SLOW    = 5;
    localparam int BIT_ST_FAST    = 4;

    // -------------------------------------------------------------------
    // Reset values and fuse decode
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_CTRL       = 8'h00;
    localparam logic [1:0] FUSE_SEL_20M   = 2'h2;

    // -------------------------------------------------------------------
    // Timing counts, in oscillator cycles
    // -------------------------------------------------------------------
    localparam int GATE_OPEN_CYC  = 4;
    localparam int XTAL_REQ_CYC   = 2;
    localparam int XTAL_SU_1K     = 1024;
    localparam int XTAL_SU_16K    = 16384;
    localparam int XTAL_SU_32K    = 32768;
    localparam int XTAL_SU_64K    = 65536;

    // -------------------------------------------------------------------
    // Register port request
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } occ_bus_req_t;

endpackage

// ### occ_osc_ctrl.sv
// Oscillator control and calibration: fast RC, slow RC and crystal.
// Assumes oscillator cycles arrive as one-cycle tick pulses synchronous
// to core_clk_in, and that fuse inputs are stable from reset release.
//
// Summary of operation
// - Keep-running bit holds an internal oscillator on whether used or not.
// - Internal oscillator clock is gated out only while requested.
// - Gate opens four oscillator cycles after request; start-up only if not kept.
// - Six-bit frequency trim at bits 5:0, loaded from fuse-selected factory value.
// - Lock flag bit 7 read-only; while set, both trim registers ignore writes.
// - Lock flag loads from the oscillator lock fuse bit at reset.
// - Four-bit temperature slope at bits 3:0, loaded from fuse-selected value.
// - Source type and start-up writes ignored while enabled or stable flag high.
// - Start-up select 0..3 waits 1k, 16k, 32k, 64k crystal cycles.
// - External clock source skips the crystal start-up wait entirely.
// - Source bit 2: 0 crystal across both pins, 1 clock on first pin.
// - Crystal runs when enabled and either kept running or requested.
// - Crystal output reaches peripherals only while requested.
// - Started kept crystal gates out two cycles after request.
// - Crystal enable and keep-running writes need the I/O unlock.
// - Enable overrides both oscillator pins and freezes source and start-up.
// - Crystal stable flag set only when started and requested.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps

module occ_osc_ctrl #(
    parameter logic [5:0] FAST_TRIM_16M   = 6'h20,
    parameter logic [5:0] FAST_TRIM_20M   = 6'h20,
    parameter logic [3:0] FAST_SLOPE_16M  = 4'h8,
    parameter logic [3:0] FAST_SLOPE_20M  = 4'h8,
    parameter int         RC_STARTUP_CYC  = 8,
    parameter int         XTAL_SU_CYC_0   = occ_pkg::XTAL_SU_1K,
    parameter int         XTAL_SU_CYC_1   = occ_pkg::XTAL_SU_16K,
    parameter int         XTAL_SU_CYC_2   = occ_pkg::XTAL_SU_32K,
    parameter int         XTAL_SU_CYC_3   = occ_pkg::XTAL_SU_64K
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 sys_rst_in,
    input  wire occ_pkg::occ_bus_req_t bus_in,
    output logic [7:0]                rdata_out,
    input  wire logic                 ccp_unlock_in,
    input  wire logic                 io_unlock_in,
    input  wire logic [1:0]           freq_select_fuse_bits_in,
    input  wire logic                 osc_lock_fuse_bit_in,
    input  wire logic                 fast_req_in,
    input  wire logic                 fast_tick_in,
    input  wire logic                 slow_req_in,
    input  wire logic                 slow_tick_in,
    input  wire logic                 crystal_req_in,
    input  wire logic                 crystal_tick_in,
    output logic                      fast_run_out,
    output logic                      fast_gate_out,
    output logic                      slow_run_out,
    output logic                      slow_gate_out,
    output logic                      crystal_run_out,
    output logic                      crystal_gate_out,
    output logic                      crystal_pin_override_out,
    output logic                      crystal_ext_clock_out,
    output logic                      crystal_stable_flag_out
);

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    if (RC_STARTUP_CYC < 0 ||
        RC_STARTUP_CYC + occ_pkg::GATE_OPEN_CYC > 255)
    begin : g_bad_rc
        $error("RC start-up count out of range");
    end
    if (XTAL_SU_CYC_0 < 1 || XTAL_SU_CYC_1 < 1 || XTAL_SU_CYC_2 < 1 ||
        XTAL_SU_CYC_3 < 1 || XTAL_SU_CYC_3 > 131072)
    begin : g_bad_xtal
        $error("Crystal start-up count out of range");
    end
    // The gate counters are narrow, so package counts must stay small
    if (occ_pkg::GATE_OPEN_CYC < 1 || occ_pkg::XTAL_REQ_CYC < 1 ||
        occ_pkg::XTAL_REQ_CYC > 4)
    begin : g_bad_pkg
        $error("Package gate counts out of range");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    // Index 0 of keep, irun, igate and icnt is the fast RC, 1 the slow RC
    typedef struct packed {
        logic [7:0]      rdata;
        logic            load_pend;
        logic [1:0]      keep;
        logic [5:0]      trim;
        logic [3:0]      slope;
        logic            lock;
        logic            x_en;
        logic            x_keep;
        logic            x_sel;
        logic [1:0]      x_crystal_startup_sel;
        logic [1:0]      irun;
        logic [1:0]      igate;
        logic [1:0][7:0] icnt;
        logic            xrun;
        logic [16:0]     xcnt;
        logic            xstarted;
        logic [1:0]      xreq_cnt;
        logic            xgate;
        logic            xstable;
    } occ_state_t;

    occ_state_t st_r;
    occ_state_t st_nxt;

    // Start-up limit in crystal cycles for a start-up select code
    function automatic logic [16:0] xtal_limit(input logic [1:0] sel);
        logic [16:0] lim;
        lim = 17'h00000;
        case (sel)
            2'h0:    lim = 17'(XTAL_SU_CYC_0 - 1);
            2'h1:    lim = 17'(XTAL_SU_CYC_1 - 1);
            2'h2:    lim = 17'(XTAL_SU_CYC_2 - 1);
            default: lim = 17'(XTAL_SU_CYC_3 - 1);
        endcase
        return lim;
    endfunction

    logic [1:0] ireq;
    logic [1:0] itick;
    logic       wr_ok;
    assign ireq  = {slow_req_in, fast_req_in};
    assign itick = {slow_tick_in, fast_tick_in};
    // Every write needs the change window; crystal enable and keep-running need a second one
    assign wr_ok = bus_in.wr & ccp_unlock_in;

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] tgt;
        tgt    = 8'h00;
        st_nxt = st_r;

        // Register writes
        if (wr_ok)
        begin
            case (bus_in.addr)
                occ_pkg::OFS_FAST_CTRL:
                    st_nxt.keep[0] = bus_in.wdata[occ_pkg::BIT_KEEP_RUN];
                occ_pkg::OFS_FAST_TRIM:
                    if (!st_r.lock)
                    begin
                        st_nxt.trim = bus_in.wdata[5:0];
                    end
                occ_pkg::OFS_FAST_TEMP:
                    if (!st_r.lock)
                    begin
                        st_nxt.slope = bus_in.wdata[3:0];
                    end
                occ_pkg::OFS_SLOW_CTRL:
                    st_nxt.keep[1] = bus_in.wdata[occ_pkg::BIT_KEEP_RUN];
                occ_pkg::OFS_XTAL_CTRL:
                begin
                    if (io_unlock_in)
                    begin
                        st_nxt.x_en =
                            bus_in.wdata[occ_pkg::BIT_XTAL_EN];
                        st_nxt.x_keep =
                            bus_in.wdata[occ_pkg::BIT_KEEP_RUN];
                    end
                    // Checked against the state before this write, so
                    // the write that sets enable still lands these bits
                    if (!st_r.x_en && !st_r.xstable)
                    begin
                        st_nxt.x_sel =
                            bus_in.wdata[occ_pkg::BIT_XTAL_SEL];
                        st_nxt.x_crystal_startup_sel =
                            bus_in.wdata[occ_pkg::POS_CRYSTAL_STARTUP_SEL +: 2];
                    end
                end
                default: ;
            endcase
        end

        // Factory calibration and lock load on the first edge after reset
        // Placed after the writes so that the fuse values win that cycle
        if (st_r.load_pend)
        begin
            st_nxt.load_pend = 1'b0;
            if (freq_select_fuse_bits_in == occ_pkg::FUSE_SEL_20M)
            begin
                st_nxt.trim  = FAST_TRIM_20M;
                st_nxt.slope = FAST_SLOPE_20M;
            end
            else
            begin
                st_nxt.trim  = FAST_TRIM_16M;
                st_nxt.slope = FAST_SLOPE_16M;
            end
            st_nxt.lock = osc_lock_fuse_bit_in;
        end

        // Internal RC oscillators
        for (int i = 0; i < 2; i++)
        begin
            st_nxt.irun[i] = st_r.keep[i] | ireq[i];
            // Four cycles, plus the start-up time unless kept running
            tgt = st_r.keep[i] ?
                  8'(occ_pkg::GATE_OPEN_CYC - 1) :
                  8'(occ_pkg::GATE_OPEN_CYC + RC_STARTUP_CYC - 1);
            // A dropped request restarts the count, so each gate waits fully
            if (!ireq[i])
            begin
                st_nxt.icnt[i]  = 8'h00;
                st_nxt.igate[i] = 1'b0;
            end
            else if (itick[i] && !st_r.igate[i])
            begin
                if (st_r.icnt[i] >= tgt)
                begin
                    st_nxt.igate[i] = 1'b1;
                end
                else
                begin
                    st_nxt.icnt[i] = st_r.icnt[i] + 8'h01;
                end
            end
        end

        // Crystal oscillator
        st_nxt.xrun = st_r.x_en & (st_r.x_keep | crystal_req_in);
        // A stopped crystal has to run its whole start-up again
        if (!st_r.xrun)
        begin
            st_nxt.xcnt     = 17'h00000;
            st_nxt.xstarted = 1'b0;
        end
        else if (!st_r.xstarted)
        begin
            if (st_r.x_sel)
            begin
                st_nxt.xstarted = 1'b1;
            end
            else if (crystal_tick_in)
            begin
                if (st_r.xcnt >= xtal_limit(st_r.x_crystal_startup_sel))
                begin
                    st_nxt.xstarted = 1'b1;
                end
                else
                begin
                    st_nxt.xcnt = st_r.xcnt + 17'h00001;
                end
            end
        end

        // Clearing enable closes the gate at once, never after run drops
        if (!crystal_req_in || !st_r.xrun || !st_r.x_en)
        begin
            st_nxt.xreq_cnt = 2'h0;
            st_nxt.xgate    = 1'b0;
        end
        else if (st_r.xstarted && crystal_tick_in && !st_r.xgate)
        begin
            if (st_r.xreq_cnt == 2'(occ_pkg::XTAL_REQ_CYC - 1))
            begin
                st_nxt.xgate = 1'b1;
            end
            else
            begin
                st_nxt.xreq_cnt = st_r.xreq_cnt + 2'h1;
            end
        end
        // Follows the request, so it clears as soon as nobody asks
        st_nxt.xstable = st_r.xrun & st_r.xstarted
                       & crystal_req_in;

        // Read data, valid only in the cycle after the read strobe
        // Unmapped addresses and reserved bits return zero
        st_nxt.rdata = 8'h00;
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                occ_pkg::OFS_STATUS:
                begin
                    st_nxt.rdata[occ_pkg::BIT_ST_XTAL] = st_r.xstable;
                    st_nxt.rdata[occ_pkg::BIT_ST_SLOW] = st_r.igate[1];
                    st_nxt.rdata[occ_pkg::BIT_ST_FAST] = st_r.igate[0];
                end
                occ_pkg::OFS_FAST_CTRL:
                    st_nxt.rdata[occ_pkg::BIT_KEEP_RUN] = st_r.keep[0];
                occ_pkg::OFS_FAST_TRIM:
                    st_nxt.rdata[5:0] = st_r.trim;
                occ_pkg::OFS_FAST_TEMP:
                begin
                    st_nxt.rdata[occ_pkg::BIT_CAL_LOCK] = st_r.lock;
                    st_nxt.rdata[3:0] = st_r.slope;
                end
                occ_pkg::OFS_SLOW_CTRL:
                    st_nxt.rdata[occ_pkg::BIT_KEEP_RUN] = st_r.keep[1];
                occ_pkg::OFS_XTAL_CTRL:
                begin
                    st_nxt.rdata[occ_pkg::POS_CRYSTAL_STARTUP_SEL +: 2] = st_r.x_crystal_startup_sel;
                    st_nxt.rdata[occ_pkg::BIT_XTAL_SEL]  = st_r.x_sel;
                    st_nxt.rdata[occ_pkg::BIT_KEEP_RUN]  = st_r.x_keep;
                    st_nxt.rdata[occ_pkg::BIT_XTAL_EN]   = st_r.x_en;
                end
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_r           <= '0;
            // Fuses are taken on the first edge after release
            st_r.load_pend <= 1'b1;
            st_r.keep      <= occ_pkg::RST_CTRL[1:0];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign rdata_out                = st_r.rdata;
    assign fast_run_out             = st_r.irun[0];
    assign fast_gate_out            = st_r.igate[0];
    assign slow_run_out             = st_r.irun[1];
    assign slow_gate_out            = st_r.igate[1];
    assign crystal_run_out          = st_r.xrun;
    assign crystal_gate_out         = st_r.xgate;
    // Pins belong to the oscillator for as long as enable is set
    assign crystal_pin_override_out = st_r.x_en;
    assign crystal_ext_clock_out    = st_r.x_sel;
    assign crystal_stable_flag_out  = st_r.xstable;

endmodule // occ_osc_ctrl

// ### occ_osc_ctrl_asserts.sv
// Checker: port timing of the oscillator control and calibration block.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/10ps

module occ_osc_ctrl_chk (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic fast_req_in,
    input wire logic slow_req_in,
    input wire logic crystal_req_in,
    input wire logic fast_run_out,
    input wire logic fast_gate_out,
    input wire logic slow_run_out,
    input wire logic slow_gate_out,
    input wire logic crystal_run_out,
    input wire logic crystal_gate_out,
    input wire logic crystal_pin_override_out,
    input wire logic crystal_stable_flag_out
);
    // -------------------------------------------------------------------
    // Relations between requests, runs and gates
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    fast_run_req_a: assert property (
        $past(fast_req_in) |-> fast_run_out)
        else $error("fast oscillator stopped while requested");
    slow_run_req_a: assert property (
        $past(slow_req_in) |-> slow_run_out)
        else $error("slow oscillator stopped while requested");
    fast_gate_req_a: assert property (
        fast_gate_out |-> $past(fast_req_in))
        else $error("fast gate open without request");
    slow_gate_req_a: assert property (
        slow_gate_out |-> $past(slow_req_in))
        else $error("slow gate open without request");
    fast_gate_wait_a: assert property (
        $rose(fast_req_in) |-> ##1 !fast_gate_out [*3])
        else $error("fast gate opened too early");
    slow_gate_wait_a: assert property (
        $rose(slow_req_in) |-> ##1 !slow_gate_out [*3])
        else $error("slow gate opened too early");
    xtal_run_en_a: assert property (
        crystal_run_out
        |-> crystal_pin_override_out || $past(crystal_pin_override_out))
        else $error("crystal runs while disabled");
    xtal_gate_req_a: assert property (
        crystal_gate_out |-> $past(crystal_req_in) && crystal_run_out)
        else $error("crystal output without request");
    xtal_stable_req_a: assert property (
        crystal_stable_flag_out |-> $past(crystal_req_in))
        else $error("crystal stable flag without request");
endmodule // occ_osc_ctrl_chk

bind occ_osc_ctrl occ_osc_ctrl_chk u_chk (
    .core_clk_in, .sys_rst_in, .fast_req_in, .slow_req_in,
    .crystal_req_in, .fast_run_out, .fast_gate_out, .slow_run_out,
    .slow_gate_out, .crystal_run_out, .crystal_gate_out,
    .crystal_pin_override_out, .crystal_stable_flag_out
);

// ### occ_xtal_model.sv
// Model: external 32.768 kHz crystal or clock, seen as tick pulses.
// Assumes the block's crystal run output tells when the source swings.
`timescale 1ns/10ps

module occ_xtal_model #(
    parameter int PERIOD = 3
) (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic run_in,
    output logic      tick_out
);
    int phase;

    // -------------------------------------------------------------------
    // Source stands still unless the block runs it
    // -------------------------------------------------------------------
    always @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in || !run_in)
        begin
            phase    <= 0;
            tick_out <= 1'b0;
        end
        else
        begin
            phase    <= (phase == PERIOD - 1) ? 0 : phase + 1;
            tick_out <= (phase == PERIOD - 1);
        end
    end
endmodule // occ_xtal_model

// ### occ_osc_ctrl_tb.sv
// Testbench: register port, internal oscillator gates and crystal start.
// Assumes shortened start-up counts and ticks made on the core clock.
`timescale 1ns/10ps

module occ_osc_ctrl_tb;
    localparam logic [5:0] T16 = 6'h15;
    localparam logic [5:0] T20 = 6'h2A;
    localparam logic [3:0] S16 = 4'h3;
    localparam logic [3:0] S20 = 4'hC;
    localparam int         SU [4] = '{4, 8, 12, 16};
    localparam logic [4:0] XC = occ_pkg::OFS_XTAL_CTRL;
    localparam logic [4:0] TR = occ_pkg::OFS_FAST_TRIM;
    localparam logic [4:0] TP = occ_pkg::OFS_FAST_TEMP;

    logic                  core_clk_in = 1'b0;
    logic                  sys_rst_in = 1'b1;
    occ_pkg::occ_bus_req_t bus_in = '0;
    logic [7:0]            rdata_out;
    logic                  ccp_unlock_in = 1'b0;
    logic                  io_unlock_in = 1'b0;
    logic [1:0]            freq_select_fuse_bits_in = 2'h2;
    logic                  osc_lock_fuse_bit_in = 1'b0;
    logic                  fast_req_in = 1'b0;
    logic                  fast_tick_in = 1'b0;
    logic                  slow_req_in = 1'b0;
    logic                  slow_tick_in = 1'b0;
    logic                  crystal_req_in = 1'b0;
    logic                  crystal_tick_in;
    logic                  fast_run_out, fast_gate_out, slow_run_out;
    logic                  slow_gate_out, crystal_run_out, crystal_gate_out;
    logic                  crystal_pin_override_out, crystal_ext_clock_out;
    logic                  crystal_stable_flag_out;
    logic [2:0]            gates;
    int                    cnt [3] = '{0, 0, 0};
    int                    cyc = 0;
    int                    n_errors = 0;
    int                    num_checks = 0;

    assign gates = {crystal_gate_out, slow_gate_out, fast_gate_out};

    occ_osc_ctrl #(.FAST_TRIM_16M(T16), .FAST_TRIM_20M(T20),
        .FAST_SLOPE_16M(S16), .FAST_SLOPE_20M(S20), .RC_STARTUP_CYC(2),
        .XTAL_SU_CYC_0(SU[0]), .XTAL_SU_CYC_1(SU[1]),
        .XTAL_SU_CYC_2(SU[2]), .XTAL_SU_CYC_3(SU[3])) dut (
        .core_clk_in, .sys_rst_in, .bus_in, .rdata_out, .ccp_unlock_in,
        .io_unlock_in, .freq_select_fuse_bits_in, .osc_lock_fuse_bit_in,
        .fast_req_in, .fast_tick_in, .slow_req_in, .slow_tick_in,
        .crystal_req_in, .crystal_tick_in, .fast_run_out, .fast_gate_out,
        .slow_run_out, .slow_gate_out, .crystal_run_out, .crystal_gate_out,
        .crystal_pin_override_out, .crystal_ext_clock_out,
        .crystal_stable_flag_out);

    occ_xtal_model u_xtal (.core_clk_in, .sys_rst_in,
        .run_in(crystal_run_out), .tick_out(crystal_tick_in));

    // -------------------------------------------------------------------
    // Clock, oscillator ticks, tick counts per request, timeout
    // -------------------------------------------------------------------
    always #2.5 core_clk_in = ~core_clk_in;

    always @(posedge core_clk_in)
    begin
        cyc          <= cyc + 1;
        fast_tick_in <= ~cyc[0];
        slow_tick_in <= (cyc[1:0] == 2'h3);
        cnt[0] <= fast_req_in ? cnt[0] + fast_tick_in : 0;
        cnt[1] <= slow_req_in ? cnt[1] + slow_tick_in : 0;
        cnt[2] <= crystal_req_in ? cnt[2] + crystal_tick_in : 0;
        if (cyc == 6000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus_in <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_in);
        bus_in.wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        bus_in.addr <= a;
        bus_in.rd   <= 1'b1;
        @(posedge core_clk_in);
        bus_in.rd <= 1'b0;
        #1 chk(rdata_out, e);
    endtask

    task automatic wait_gate(input int w, input int n);
        int i;
        i = 0;
        while (i < 400 && gates[w] !== 1'b1)
        begin
            @(posedge core_clk_in);
            #1 i++;
        end
        chk(gates[w], 1);
        chk(cnt[w], n);
    endtask

    task automatic settle();
        repeat (3) @(posedge core_clk_in);
        #1;
    endtask

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        rd(TR, {2'h0, T20});
        rd(TP, {4'h0, S20});
        rd(XC, 8'h00);
        rd(5'h05, 8'h00);
        wr(TR, 8'hFF);
        rd(TR, {2'h0, T20});
        @(posedge core_clk_in) ccp_unlock_in <= 1'b1;
        wr(TR, 8'hFF);
        rd(TR, 8'h3F);
        wr(TP, 8'hFF);
        rd(TP, 8'h0F);
        wr(occ_pkg::OFS_FAST_CTRL, 8'h02);
        settle();
        chk(fast_run_out, 1);
        chk(fast_gate_out, 0);
        @(posedge core_clk_in) fast_req_in <= 1'b1;
        wait_gate(0, 4);
        rd(occ_pkg::OFS_STATUS, 8'h10);
        @(posedge core_clk_in) slow_req_in <= 1'b1;
        wait_gate(1, 6);
        @(posedge core_clk_in) fast_req_in <= 1'b0;
        slow_req_in <= 1'b0;
        settle();
        chk(gates, 3'h0);
        chk({fast_run_out, slow_run_out}, 2'h2);
        wr(XC, 8'h33);
        rd(XC, 8'h30);
        @(posedge core_clk_in) io_unlock_in <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            wr(XC, {2'h0, k[1:0], 4'h0});
            wr(XC, {2'h0, k[1:0], 4'h1});
            wr(XC, 8'h05);
            rd(XC, {2'h0, k[1:0], 4'h1});
            chk(crystal_pin_override_out, 1);
            @(posedge core_clk_in) crystal_req_in <= 1'b1;
            wait_gate(2, SU[k] + 2);
            chk(crystal_stable_flag_out, 1);
            @(posedge core_clk_in) crystal_req_in <= 1'b0;
            wr(XC, {2'h0, k[1:0], 4'h0});
            settle();
            chk(crystal_stable_flag_out, 0);
        end
        wr(XC, 8'h05);
        rd(XC, 8'h05);
        chk(crystal_ext_clock_out, 1);
        @(posedge core_clk_in) crystal_req_in <= 1'b1;
        wait_gate(2, 2);
        @(posedge core_clk_in) crystal_req_in <= 1'b0;
        wr(XC, 8'h07);
        settle();
        chk({crystal_run_out, crystal_stable_flag_out}, 2'h2);
        @(posedge core_clk_in) crystal_req_in <= 1'b1;
        wait_gate(2, 2);
        wr(XC, 8'h36);
        wr(XC, 8'h36);
        rd(XC, 8'h06);
        @(posedge core_clk_in) crystal_req_in <= 1'b0;
        settle();
        @(posedge core_clk_in) osc_lock_fuse_bit_in <= 1'b1;
        freq_select_fuse_bits_in <= 2'h0;
        sys_rst_in               <= 1'b1;
        settle();
        @(posedge core_clk_in) sys_rst_in <= 1'b0;
        rd(TP, {4'h8, S16});
        wr(TR, 8'h00);
        wr(TP, 8'h00);
        rd(TR, {2'h0, T16});
        rd(TP, {4'h8, S16});
        print_verdict();
    end
endmodule // occ_osc_ctrl_tb
